// file: rtl/ochc_consts.svh
`ifndef OCHC_CONSTS_SVH
`define OCHC_CONSTS_SVH

// ***************************************************************
// Clock rate
// ***************************************************************
`define OCHC_CLK_HZ          25000000
`define OCHC_CYC_PER_MS      (`OCHC_CLK_HZ / 1000)

// ***************************************************************
// Register offsets
// ***************************************************************
`define OCHC_ADDR_RAMP_CFG   8'h0e
`define OCHC_ADDR_SCALE      8'h17
`define OCHC_ADDR_STATUS     8'h20
`define OCHC_ADDR_IRQ_CLR    8'h21

// ***************************************************************
// Field positions and reset values
// ***************************************************************
`define OCHC_RAMP_SEL_LSB    0
`define OCHC_DLY_SEL_LSB     2
`define OCHC_SINK_EN_BIT     4
`define OCHC_CC_FLAG_BIT     3
`define OCHC_IRQ_CLR_BIT     0
`define OCHC_RAMP_CFG_RST    8'h00
`define OCHC_SCALE_RST       7'h64
`define OCHC_SCALE_MIN       7'h01
`define OCHC_SCALE_MAX       7'h64

// ***************************************************************
// State codes for the status field; OCHC_ST_LL_OFF is never driven
// ***************************************************************
`define OCHC_ST_RESTART      3'h0
`define OCHC_ST_SOFT         3'h1
`define OCHC_ST_REGUL        3'h2
`define OCHC_ST_RETRY        3'h3
`define OCHC_ST_LL_OFF       3'h4

// ***************************************************************
// Times in ms and derived cycle counts
// ***************************************************************
`define OCHC_RETRY_MS        3000
`define OCHC_DLY1_MS         10
`define OCHC_DLY2_MS         100
`define OCHC_DLY3_MS         1000
`define OCHC_SS0_MS          1
`define OCHC_SS1_MS          2
`define OCHC_SS2_MS          4
`define OCHC_SS3_MS          8
`define OCHC_RETRY_CYC       (`OCHC_RETRY_MS * `OCHC_CYC_PER_MS)
`define OCHC_DLY1_CYC        (`OCHC_DLY1_MS * `OCHC_CYC_PER_MS)
`define OCHC_DLY2_CYC        (`OCHC_DLY2_MS * `OCHC_CYC_PER_MS)
`define OCHC_DLY3_CYC        (`OCHC_DLY3_MS * `OCHC_CYC_PER_MS)
`define OCHC_SS0_CYC         (`OCHC_SS0_MS * `OCHC_CYC_PER_MS)
`define OCHC_SS1_CYC         (`OCHC_SS1_MS * `OCHC_CYC_PER_MS)
`define OCHC_SS2_CYC         (`OCHC_SS2_MS * `OCHC_CYC_PER_MS)
`define OCHC_SS3_CYC         (`OCHC_SS3_MS * `OCHC_CYC_PER_MS)

`endif

// file: rtl/ochc_pkg.sv
package ochc_pkg;
	// ***************************************************************
	// Power-on sequencer states
	// ***************************************************************
	typedef enum logic [2:0] {
		ochc_off,
		ochc_restart,
		ochc_soft,
		ochc_regul,
		ochc_retry
	} ochc_state_e;
	typedef logic [7:0] ochc_byte_t;
	typedef logic [31:0] ochc_count_t;
endpackage

// file: rtl/ochc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ochc_consts.svh"
// Notes on behaviour
// - Sink turns on when target is lowered
// - Sink turns off once output regulates
// - Delay timer starts when startup is valid
// - Two-bit field picks delay, zero to 1s
// - Soft ramp begins only after delay ends
// - Ramp time depends only on ramp field
// - Seven-bit scale sets limit in percent
// - Zero reads back zero, applies one percent
// - Above hundred kept, applied limit saturates
// - Over limit, regulate constant current instead
// - Status flag shows voltage or current mode
// - Low output enters retry, output off 3s
// - After retry interval, restart and start up
// - Persistent fault repeats retry cycle forever
// - Retry entry pulls interrupt low until cleared
// - Status field encodes sequencer state codes
module ochc_top #(
	parameter ochc_pkg::ochc_count_t RETRY_CYC = `OCHC_RETRY_CYC,
	parameter ochc_pkg::ochc_count_t DLY1_CYC  = `OCHC_DLY1_CYC,
	parameter ochc_pkg::ochc_count_t DLY2_CYC  = DLY1_CYC * (`OCHC_DLY2_MS / `OCHC_DLY1_MS),
	parameter ochc_pkg::ochc_count_t DLY3_CYC  = DLY1_CYC * (`OCHC_DLY3_MS / `OCHC_DLY1_MS),
	parameter ochc_pkg::ochc_count_t SS0_CYC   = `OCHC_SS0_CYC,
	parameter ochc_pkg::ochc_count_t SS1_CYC   = SS0_CYC * (`OCHC_SS1_MS / `OCHC_SS0_MS),
	parameter ochc_pkg::ochc_count_t SS2_CYC   = SS0_CYC * (`OCHC_SS2_MS / `OCHC_SS0_MS),
	parameter ochc_pkg::ochc_count_t SS3_CYC   = SS0_CYC * (`OCHC_SS3_MS / `OCHC_SS0_MS)
) (
	input  wire logic              clk_sys,           // System clock, 25 MHz
	input  wire logic              arst_n,            // Async reset, low
	input  wire ochc_pkg::ochc_byte_t reg_addr,       // Register index
	input  wire ochc_pkg::ochc_byte_t reg_wdata,      // Write data
	input  wire logic              reg_wr,            // Write strobe
	input  wire logic              reg_rd,            // Read strobe
	output ochc_pkg::ochc_byte_t   reg_rdata,         // Read data, registered
	input  wire logic              converter_enable,  // Pin: startup valid
	input  wire logic              vout_below_fault,  // Pin: output under 3V
	input  wire logic              vout_in_regulation,// Pin: output regulated
	input  wire logic              current_limit_hit, // Pin: load at limit
	input  wire logic              vout_target_lowered,// Same-domain step-down pulse
	output logic                   converter_run,     // Power stage allowed to switch
	output logic                   soft_start_active, // Ramp in progress
	output logic                   sink_on,           // Discharge sink enable
	output logic                   cc_mode,           // Constant-current regulation
	output logic [6:0]             applied_limit_pct, // Limit handed to the loop
	output logic [2:0]             power_state,       // State code
	output logic                   interrupt_out_n    // Interrupt, low active
);
	import ochc_pkg::*;

	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	logic [3:0] sync_a;     // First stage, read only by sync_b
	logic [3:0] sync_b;     // Safe copies
	logic       reg_prev;   // Delayed regulation copy for edge
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync_a   <= 4'h0;
			sync_b   <= 4'h0;
			reg_prev <= 1'b0;
		end else begin
			sync_a   <= {current_limit_hit, vout_in_regulation, vout_below_fault, converter_enable};
			sync_b   <= sync_a;
			reg_prev <= sync_b[2];
		end
	end
	logic en_s;       // Startup conditions valid
	logic fault_s;    // Output below fault threshold
	logic inreg_s;    // Output in regulation
	logic climit_s;   // Load pushing against limit
	assign en_s     = sync_b[0];
	assign fault_s  = sync_b[1];
	assign inreg_s  = sync_b[2];
	assign climit_s = sync_b[3];
	// ***************************************************************
	// Registers
	// ***************************************************************
	ochc_byte_t ramp_cfg;   // Ramp, delay and sink controls
	logic [6:0] scale;      // Limit scale, kept as written
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ramp_cfg <= `OCHC_RAMP_CFG_RST;
			scale    <= `OCHC_SCALE_RST;
		end else if (reg_wr) begin
			if (reg_addr == `OCHC_ADDR_RAMP_CFG) begin
				ramp_cfg <= reg_wdata;
			end
			// Stored verbatim so zero and over-range read back
			if (reg_addr == `OCHC_ADDR_SCALE) begin
				scale <= reg_wdata[6:0];
			end
		end
	end
	logic [1:0] ramp_sel;   // Soft-start time choice
	logic [1:0] dly_sel;    // Startup delay choice
	logic       sink_en;    // Downward discharge allowed
	assign ramp_sel = ramp_cfg[`OCHC_RAMP_SEL_LSB +: 2];
	assign dly_sel  = ramp_cfg[`OCHC_DLY_SEL_LSB +: 2];
	assign sink_en  = ramp_cfg[`OCHC_SINK_EN_BIT];
	// ***************************************************************
	// Applied current limit
	// ***************************************************************
	// Clamp only the copy given to the loop
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			applied_limit_pct <= `OCHC_SCALE_RST;
		end else if (scale == 7'h00) begin
			applied_limit_pct <= `OCHC_SCALE_MIN;
		end else if (scale > `OCHC_SCALE_MAX) begin
			applied_limit_pct <= `OCHC_SCALE_MAX;
		end else begin
			applied_limit_pct <= scale;
		end
	end

	// ***************************************************************
	// Sequencer
	// ***************************************************************
	ochc_state_e state;        // Current state
	ochc_state_e next_state;   // Next state
	ochc_count_t tmr;          // Shared state timer
	ochc_count_t dly_len;      // Selected delay length
	ochc_count_t ss_len;       // Selected ramp length
	logic        entering;     // State changes this edge
	// Delay options, monotonic
	always_comb begin
		case (dly_sel)
			2'd0:    dly_len = 32'h0;
			2'd1:    dly_len = DLY1_CYC;
			2'd2:    dly_len = DLY2_CYC;
			default: dly_len = DLY3_CYC;
		endcase
	end
	// Ramp length ignores the voltage target entirely
	always_comb begin
		case (ramp_sel)
			2'd0:    ss_len = SS0_CYC;
			2'd1:    ss_len = SS1_CYC;
			2'd2:    ss_len = SS2_CYC;
			default: ss_len = SS3_CYC;
		endcase
	end
	// Transitions; disable wins from every state
	always_comb begin
		next_state = state;
		if (!en_s) begin
			next_state = ochc_off;
		end else begin
			case (state)
				ochc_off:     next_state = ochc_restart;
				ochc_restart: begin
					// Ramp only after delay has run out
					if (tmr >= dly_len) begin
						next_state = ochc_soft;
					end
				end
				ochc_soft: begin
					// A fault still present at ramp end means retry
					if (tmr + 32'h1 >= ss_len) begin
						next_state = fault_s ? ochc_retry : ochc_regul;
					end
				end
				ochc_regul: begin
					if (fault_s) begin
						next_state = ochc_retry;
					end
				end
				ochc_retry: begin
					if (tmr + 32'h1 >= RETRY_CYC) begin
						next_state = ochc_restart;
					end
				end
				default:      next_state = ochc_off;
			endcase
		end
	end
	assign entering = (next_state != state);
	// State and timer; timer restarts on every entry
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= ochc_off;
			tmr   <= 32'h0;
		end else begin
			state <= next_state;
			tmr   <= entering ? 32'h0 : tmr + 32'h1;
		end
	end

	// ***************************************************************
	// Power stage outputs and status
	// ***************************************************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			converter_run     <= 1'b0;
			soft_start_active <= 1'b0;
			cc_mode           <= 1'b0;
			power_state       <= `OCHC_ST_RESTART;
		end else begin
			// Output held off during retry interval
			converter_run     <= (next_state == ochc_soft) || (next_state == ochc_regul);
			soft_start_active <= (next_state == ochc_soft);
			cc_mode           <= climit_s && (next_state == ochc_regul);
			case (next_state)
				ochc_soft:  power_state <= `OCHC_ST_SOFT;
				ochc_regul: power_state <= `OCHC_ST_REGUL;
				ochc_retry: power_state <= `OCHC_ST_RETRY;
				default:    power_state <= `OCHC_ST_RESTART;
			endcase
		end
	end

	// ***************************************************************
	// Discharge sink
	// ***************************************************************
	// Turned off on the regulation edge, not the level, since
	// the level is still high right after the step-down.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sink_on <= 1'b0;
		end else if (sink_en && vout_target_lowered && state == ochc_regul) begin
			sink_on <= 1'b1;
		end else if ((inreg_s && !reg_prev) || state != ochc_regul || !sink_en) begin
			sink_on <= 1'b0;
		end
	end

	// ***************************************************************
	// Interrupt
	// ***************************************************************
	logic irq_clr;   // Host clear write
	assign irq_clr = reg_wr && reg_addr == `OCHC_ADDR_IRQ_CLR && reg_wdata[`OCHC_IRQ_CLR_BIT];
	// New retry entry beats a clear in the same cycle
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			interrupt_out_n <= 1'b1;
		end else if (entering && next_state == ochc_retry) begin
			interrupt_out_n <= 1'b0;
		end else if (irq_clr) begin
			interrupt_out_n <= 1'b1;
		end
	end

	// ***************************************************************
	// Read port
	// ***************************************************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`OCHC_ADDR_RAMP_CFG: reg_rdata <= ramp_cfg;
				`OCHC_ADDR_SCALE:    reg_rdata <= {1'b0, scale};
				`OCHC_ADDR_STATUS:   reg_rdata <= {4'h0, cc_mode, power_state};
				default:             reg_rdata <= 8'h00; // Unmapped reads zero
			endcase
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	a_zero_scale: assert property (@(posedge clk_sys) disable iff (!arst_n)
		scale == 7'h00 |=> applied_limit_pct == 7'h01)
		else $error("zero scale not applied as one percent");
	a_scale_sat: assert property (@(posedge clk_sys) disable iff (!arst_n)
		scale > 7'h64 |=> applied_limit_pct == 7'h64)
		else $error("over-range scale not saturated");
	a_scale_pass: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(scale != 7'h00 && scale <= 7'h64) |=> applied_limit_pct == $past(scale))
		else $error("in-range scale not applied");
	a_retry_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state == ochc_retry |-> !converter_run)
		else $error("output on during retry");
	a_fault_retry: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(state == ochc_regul && fault_s && en_s) |=> state == ochc_retry ##0 power_state == 3'h3)
		else $error("fault did not enter retry");
	a_retry_irq: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(state != ochc_retry && next_state == ochc_retry) |=> !interrupt_out_n)
		else $error("interrupt not raised on retry entry");
	a_timer_entry: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$changed(state) |-> tmr == 32'h0)
		else $error("timer not cleared on entry");
	a_soft_after: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(state == ochc_restart && next_state == ochc_soft) |-> tmr >= dly_len)
		else $error("ramp began before delay");
	a_sink_step: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(sink_en && vout_target_lowered && state == ochc_regul) |=> sink_on)
		else $error("sink not turned on");
	a_cc_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(climit_s && next_state == ochc_regul) |=> cc_mode ##0 power_state == 3'h2)
		else $error("current mode not flagged");
endmodule
`default_nettype wire

// file: bench/ochc_stage_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************
// Power stage stand-in
// ************************************
module ochc_stage_model (
	input  wire logic       clk_sys,             // System clock
	input  wire logic       arst_n,              // Async reset, low
	input  wire logic       converter_run,       // Stage may switch
	input  wire logic       soft_start_active,   // Ramp running
	input  wire logic       vout_target_lowered, // Step-down pulse
	input  wire logic [6:0] applied_limit_pct,   // Limit from block
	input  wire logic [6:0] load_pct,            // Load demand
	input  wire logic       short_on,            // Output shorted
	output logic            vout_below_fault,    // Under 3V
	output logic            vout_in_regulation,  // Output settled
	output logic            current_limit_hit    // Load at limit
);
	logic [3:0] fall_cnt; // Cycles left of a slow fall
	// No load to pull the output, so a step down settles late
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			fall_cnt <= 4'h0;
		end else if (vout_target_lowered) begin
			fall_cnt <= 4'h6;
		end else if (fall_cnt != 4'h0) begin
			fall_cnt <= fall_cnt - 4'h1;
		end
	end
	assign vout_below_fault   = short_on; // A short drags output under 3V
	assign vout_in_regulation = converter_run & ~soft_start_active & (fall_cnt == 4'h0);
	assign current_limit_hit  = converter_run & (load_pct > applied_limit_pct);
endmodule
`default_nettype wire

// file: bench/ochc_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "ochc_consts.svh"
module ochc_top_bench;
	import ochc_pkg::*;
	logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0; // Clock, reset, strobes
	logic converter_enable = 1'b0, vout_target_lowered = 1'b0, short_on = 1'b0; // Pins
	ochc_byte_t reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata; // Register port
	logic [6:0] load_pct = 7'h00, applied_limit_pct; // Load and limit
	logic vbf, vir, clh, converter_run, soft_start_active, sink_on, cc_mode, interrupt_out_n;
	logic [2:0] power_state; // State code
	int error_cnt = 0, cmp_count = 0, cyc = 0, n; // Counters
	localparam int DLY1_SIM = 5; // Shortened first delay step
	localparam int SS0_SIM  = 4; // Shortened first ramp step
	int dly_tab[4] = '{0, DLY1_SIM, DLY1_SIM * (`OCHC_DLY2_MS / `OCHC_DLY1_MS),
		DLY1_SIM * (`OCHC_DLY3_MS / `OCHC_DLY1_MS)}; // Delay cycles per select
	int ss_tab[4] = '{SS0_SIM, SS0_SIM * (`OCHC_SS1_MS / `OCHC_SS0_MS),
		SS0_SIM * (`OCHC_SS2_MS / `OCHC_SS0_MS), SS0_SIM * (`OCHC_SS3_MS / `OCHC_SS0_MS)}; // Ramp cycles per select
	always #20 clk_sys = ~clk_sys;
	// The base steps and the retry time are shortened; the longer options scale from the base steps
	ochc_top #(.RETRY_CYC(50), .DLY1_CYC(DLY1_SIM), .SS0_CYC(SS0_SIM)) i_ochc_top (
		.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .converter_enable(converter_enable),
		.vout_below_fault(vbf), .vout_in_regulation(vir), .current_limit_hit(clh),
		.vout_target_lowered(vout_target_lowered), .converter_run(converter_run),
		.soft_start_active(soft_start_active), .sink_on(sink_on), .cc_mode(cc_mode),
		.applied_limit_pct(applied_limit_pct), .power_state(power_state), .interrupt_out_n(interrupt_out_n));
	ochc_stage_model i_ochc_stage_model (.clk_sys(clk_sys), .arst_n(arst_n), .converter_run(converter_run),
		.soft_start_active(soft_start_active), .vout_target_lowered(vout_target_lowered),
		.applied_limit_pct(applied_limit_pct), .load_pct(load_pct), .short_on(short_on),
		.vout_below_fault(vbf), .vout_in_regulation(vir), .current_limit_hit(clh));
	// ************************************
	// Helpers
	// ************************************
	task automatic end_of_test();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s got %h want %h", $time, msg, got, exp);
		end
	endtask
	task automatic chk_rng(input int got, input int lo, input int hi, input string msg);
		cmp_count++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s took %0d", $time, msg, got);
		end
	endtask
	// Returns on the edge; reads see what settled before it
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	// One-cycle write strobe, back to idle after the taking edge
	task automatic wr(input ochc_byte_t a, input ochc_byte_t d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input ochc_byte_t a, input ochc_byte_t exp, input string msg);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		// Data loaded at the read edge, judged one edge later
		@(posedge clk_sys);
		chk_val(reg_rdata, exp, msg);
	endtask
	// Bounded wait for a state code, cycles counted
	task automatic wait_st(input logic [2:0] st);
		n = 0;
		tick(1);
		while (power_state !== st && n < 2000) begin
			tick(1);
			n++;
		end
	endtask
	// ************************************
	// Scenarios
	// ************************************
	task automatic t_reset_and_scale();
		chk_val({1'b0, applied_limit_pct}, 8'h64, "limit reset");
		chk_val({7'h00, interrupt_out_n}, 8'h01, "irq idle");
		rd_chk(`OCHC_ADDR_STATUS, 8'h00, "status reset");
		rd_chk(8'h33, 8'h00, "unmapped read");
		wr(`OCHC_ADDR_SCALE, 8'h00);
		rd_chk(`OCHC_ADDR_SCALE, 8'h00, "zero kept");
		chk_val({1'b0, applied_limit_pct}, 8'h01, "zero applies one");
		wr(`OCHC_ADDR_SCALE, 8'h7f);
		rd_chk(`OCHC_ADDR_SCALE, 8'h7f, "high kept");
		chk_val({1'b0, applied_limit_pct}, 8'h64, "high saturates");
		wr(`OCHC_ADDR_SCALE, 8'h4b);
		rd_chk(`OCHC_ADDR_SCALE, 8'h4b, "mid kept");
		chk_val({1'b0, applied_limit_pct}, 8'h4b, "mid applied");
	endtask
	// Every delay and ramp select, delay before ramp each time
	task automatic t_startup();
		for (int i = 0; i < 4; i++) begin
			wr(`OCHC_ADDR_RAMP_CFG, 8'(i * 5));
			converter_enable <= 1'b1;
			wait_st(`OCHC_ST_SOFT);
			chk_rng(n, dly_tab[i] + 1, dly_tab[i] + 6, "startup delay");
			chk_val({6'h00, converter_run, soft_start_active}, 8'h03, "run in ramp");
			wait_st(`OCHC_ST_REGUL);
			chk_rng(n, ss_tab[i] - 1, ss_tab[i] + 2, "ramp length");
			converter_enable <= 1'b0;
			wait_st(`OCHC_ST_RESTART);
		end
	endtask
	task automatic t_cc_and_sink();
		wr(`OCHC_ADDR_RAMP_CFG, 8'h00);
		wr(`OCHC_ADDR_SCALE, 8'h32);
		converter_enable <= 1'b1;
		wait_st(`OCHC_ST_REGUL);
		load_pct <= 7'h28;
		tick(6);
		rd_chk(`OCHC_ADDR_STATUS, 8'h02, "voltage mode");
		load_pct <= 7'h3c;
		tick(6);
		rd_chk(`OCHC_ADDR_STATUS, 8'h0a, "current mode");
		chk_val({7'h00, cc_mode}, 8'h01, "current mode pin");
		load_pct <= 7'h00;
		vout_target_lowered <= 1'b1;
		tick(1);
		vout_target_lowered <= 1'b0;
		tick(2);
		chk_val({7'h00, sink_on}, 8'h00, "sink off when disabled");
		wr(`OCHC_ADDR_RAMP_CFG, 8'h10);
		vout_target_lowered <= 1'b1;
		tick(1);
		vout_target_lowered <= 1'b0;
		tick(1);
		chk_val({7'h00, sink_on}, 8'h01, "sink on");
		n = 0;
		while (sink_on !== 1'b0 && n < 40) begin
			tick(1);
			n++;
		end
		chk_rng(n, 4, 12, "sink release");
		// Readback left until the sink has settled, so the step timing stays clean
		rd_chk(`OCHC_ADDR_RAMP_CFG, 8'h10, "config kept");
	endtask
	task automatic t_hiccup();
		short_on <= 1'b1;
		wait_st(`OCHC_ST_RETRY);
		chk_rng(n, 0, 5, "fault entry");
		chk_val({6'h00, converter_run, interrupt_out_n}, 8'h00, "retry off, irq low");
		wait_st(`OCHC_ST_RESTART);
		chk_rng(n, 47, 52, "retry length");
		wait_st(`OCHC_ST_RETRY);
		chk_rng(n, 3, 10, "retry again");
		wr(`OCHC_ADDR_IRQ_CLR, 8'h01);
		tick(1);
		chk_val({7'h00, interrupt_out_n}, 8'h01, "irq cleared");
		short_on <= 1'b0;
		wait_st(`OCHC_ST_REGUL);
		chk_rng(n, 50, 70, "recovers");
	endtask
	// Hang guard, far above the expected run
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end
	initial begin
		tick(2);
		arst_n <= 1'b1;
		tick(1);
		t_reset_and_scale();
		t_startup();
		t_cc_and_sink();
		t_hiccup();
		end_of_test();
	end
endmodule
`default_nettype wire
